// >>> logic/epb_pkg.sv
// Constants, timing and state codes for the byte programming controller
package epb_pkg;

	// Array shape and counter width
	localparam int ADDR_W   = 14;
	localparam int DATA_W   = 8;
	localparam int NUM_DEV  = 4;
	localparam int CNT_W    = 24;

	// Clock rate and printed times in their own units
	localparam int CLK_MHZ       = 200;
	localparam int INIT_PULSE_US = 1000;
	localparam int STD_PULSE_US  = 50000;
	localparam int SETUP_NS      = 2000;

	// Derived cycle counts
	localparam int INIT_PULSE_CYC_DEF = INIT_PULSE_US * CLK_MHZ;
	localparam int STD_PULSE_CYC_DEF  = STD_PULSE_US * CLK_MHZ;
	localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] SYNC_CYC  = 24'h000002;

	// Fast method limits
	localparam logic [3:0] MAX_INIT_PULSES = 4'hf;
	localparam logic [5:0] OVER_MS_PER_X   = 6'h04;

	// Operations requested by the user side
	typedef enum logic [1:0] {
		EPB_OP_STD   = 2'h0,
		EPB_OP_FAST  = 2'h1,
		EPB_OP_CHECK = 2'h2
	} epb_op_t;

	// Sequencer states, Gray coded along the main path
	typedef enum logic [3:0] {
		EPB_IDLE   = 4'h0,
		EPB_VCCUP  = 4'h1,
		EPB_VPPUP  = 4'h3,
		EPB_SETUP  = 4'h2,
		EPB_PULSE  = 4'h6,
		EPB_HOLD   = 4'h7,
		EPB_VERIFY = 4'h5,
		EPB_SAMPLE = 4'h4,
		EPB_VPPDN  = 4'hc,
		EPB_VCCDN  = 4'hd
	} epb_state_t;

endpackage

// >>> logic/epb_programmer.sv
// Programming controller that drives the EPROM pins and supply switches
`timescale 1ns/1ps
module epb_programmer #(
	parameter logic [epb_pkg::CNT_W-1:0] INIT_PULSE_CYC = epb_pkg::CNT_W'(epb_pkg::INIT_PULSE_CYC_DEF),
	parameter logic [epb_pkg::CNT_W-1:0] STD_PULSE_CYC  = epb_pkg::CNT_W'(epb_pkg::STD_PULSE_CYC_DEF)
) (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// User command side
	input  wire logic                        startReq,
	input  wire epb_pkg::epb_op_t            opSel,
	input  wire logic [epb_pkg::ADDR_W-1:0]  addrIn,
	input  wire logic [epb_pkg::DATA_W-1:0]  dataIn,
	input  wire logic [epb_pkg::NUM_DEV-1:0] devSel,
	output logic                             busy,
	output logic                             done,
	output logic                             passed,
	output logic                             failed,
	output logic [3:0]                       iterCount,
	output logic [epb_pkg::DATA_W-1:0]       readData,
	// EPROM pins
	output logic [epb_pkg::ADDR_W-1:0]       epAddr,
	output logic [epb_pkg::DATA_W-1:0]       epDataOut,
	output logic                             epDataOe,
	input  wire logic [epb_pkg::DATA_W-1:0]  epDataIn,
	output logic [epb_pkg::NUM_DEV-1:0]      chipSelectN,
	output logic                             outputGateN,
	output logic                             program_strobe_n,
	// Supply switches
	output logic                             vccOn,
	output logic                             vccProg,
	output logic                             vppProg
);
	import epb_pkg::*;

	typedef struct packed {
		epb_state_t          state;
		epb_op_t             op;
		logic [CNT_W-1:0]    cnt;
		logic [3:0]          iter;
		logic [5:0]          units;
		logic                over;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
		logic [NUM_DEV-1:0]  sel;
		logic [NUM_DEV-1:0]  csN;
		logic                oeN;
		logic                pgmN;
		logic                dOe;
		logic                vcc;
		logic                vcc6;
		logic                vpp;
		logic                busy;
		logic                done;
		logic                pass;
		logic                fail;
		logic [DATA_W-1:0]   rdata;
		logic [DATA_W-1:0]   sync1;
		logic [DATA_W-1:0]   sync2;
	} epb_regs_t;

	epb_regs_t st_r;
	epb_regs_t st_nxt;

	// Last cycle of a wait of lim cycles
	function automatic logic expired(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
		return (c + 24'h000001) >= lim;
	endfunction

	// Next state and outputs
	always_comb begin
		st_nxt       = st_r;
		st_nxt.done  = 1'b0;
		st_nxt.cnt   = st_r.cnt + 24'h000001;
		// Pin data passes two flops before anything reads it
		st_nxt.sync1 = epDataIn;
		st_nxt.sync2 = st_r.sync1;
		unique case (st_r.state)
			EPB_IDLE: begin
				st_nxt.cnt = '0;
				if (startReq) begin
					st_nxt.op    = opSel;
					st_nxt.addr  = addrIn;
					st_nxt.data  = dataIn;
					st_nxt.sel   = devSel;
					st_nxt.iter  = 4'h0;
					st_nxt.over  = 1'b0;
					st_nxt.busy  = 1'b1;
					st_nxt.pass  = 1'b0;
					st_nxt.fail  = 1'b0;
					st_nxt.vcc   = 1'b1;
					// Check reads at 5 V, program work at 6 V
					st_nxt.vcc6  = (opSel != EPB_OP_CHECK);
					st_nxt.state = EPB_VCCUP;
				end
			end
			EPB_VCCUP: begin
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt = '0;
					if (st_r.op == EPB_OP_CHECK) begin
						st_nxt.state = EPB_VERIFY;
					end else begin
						st_nxt.vpp   = 1'b1;
						st_nxt.state = EPB_VPPUP;
					end
				end
			end
			EPB_VPPUP: begin
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt   = '0;
					st_nxt.state = EPB_SETUP;
				end
			end
			EPB_SETUP: begin
				// Drive byte and hold select low before any strobe
				st_nxt.dOe = 1'b1;
				st_nxt.oeN = 1'b1;
				st_nxt.csN = ~st_r.sel;
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt   = '0;
					st_nxt.pgmN  = 1'b0;
					st_nxt.state = EPB_PULSE;
					if (st_r.op == EPB_OP_FAST && !st_r.over) begin
						st_nxt.iter = st_r.iter + 4'h1;
					end
				end
			end
			EPB_PULSE: begin
				if (st_r.op == EPB_OP_STD) begin
					// Nominal width, well under the 55 ms ceiling
					if (expired(st_r.cnt, STD_PULSE_CYC)) begin
						st_nxt.pgmN  = 1'b1;
						st_nxt.cnt   = '0;
						st_nxt.state = EPB_HOLD;
					end
				end else if (expired(st_r.cnt, INIT_PULSE_CYC)) begin
					st_nxt.cnt = '0;
					// Overprogram runs as a chain of 1 ms units, 4 to 60 of them
					if (!st_r.over || st_r.units == 6'h01) begin
						st_nxt.pgmN  = 1'b1;
						st_nxt.state = EPB_HOLD;
					end else begin
						st_nxt.units = st_r.units - 6'h01;
					end
				end
			end
			EPB_HOLD: begin
				// Data stays driven past the strobe edge
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt = '0;
					st_nxt.dOe = 1'b0;
					if (st_r.over) begin
						st_nxt.pass  = 1'b1;
						st_nxt.vpp   = 1'b0;
						st_nxt.state = EPB_VPPDN;
					end else begin
						st_nxt.state = EPB_VERIFY;
					end
				end
			end
			EPB_VERIFY: begin
				// Bus released first so the device can drive it
				st_nxt.dOe  = 1'b0;
				st_nxt.pgmN = 1'b1;
				st_nxt.csN  = ~st_r.sel;
				st_nxt.oeN  = 1'b0;
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt   = '0;
					st_nxt.state = EPB_SAMPLE;
				end
			end
			EPB_SAMPLE: begin
				// Wait out the synchroniser before comparing
				if (expired(st_r.cnt, SYNC_CYC + 24'h000001)) begin
					st_nxt.cnt   = '0;
					st_nxt.rdata = st_r.sync2;
					st_nxt.oeN   = 1'b1;
					if (st_r.op == EPB_OP_CHECK) begin
						st_nxt.pass  = (st_r.sync2 == st_r.data);
						st_nxt.fail  = (st_r.sync2 != st_r.data);
						st_nxt.csN   = '1;
						st_nxt.vcc   = 1'b0;
						st_nxt.state = EPB_VCCDN;
					end else if (st_r.op == EPB_OP_STD) begin
						// A one that reads back zero can never be repaired
						st_nxt.pass  = (st_r.sync2 == st_r.data);
						st_nxt.fail  = (st_r.sync2 != st_r.data);
						st_nxt.vpp   = 1'b0;
						st_nxt.state = EPB_VPPDN;
					end else if (st_r.sync2 == st_r.data) begin
						st_nxt.over  = 1'b1;
						st_nxt.units = 6'(OVER_MS_PER_X * {2'h0, st_r.iter});
						st_nxt.state = EPB_SETUP;
					end else if (st_r.iter == MAX_INIT_PULSES) begin
						st_nxt.fail  = 1'b1;
						st_nxt.vpp   = 1'b0;
						st_nxt.state = EPB_VPPDN;
					end else begin
						st_nxt.state = EPB_SETUP;
					end
				end
			end
			EPB_VPPDN: begin
				// Select returns high to inhibit once Vpp is on its way down
				st_nxt.csN = '1;
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt   = '0;
					st_nxt.vcc   = 1'b0;
					st_nxt.state = EPB_VCCDN;
				end
			end
			EPB_VCCDN: begin
				st_nxt.vcc6 = 1'b0;
				if (expired(st_r.cnt, SETUP_CYC)) begin
					st_nxt.cnt   = '0;
					st_nxt.busy  = 1'b0;
					st_nxt.done  = 1'b1;
					st_nxt.state = EPB_IDLE;
				end
			end
			default: begin
				// Illegal code: drop to a safe, unpowered idle
				st_nxt       = '0;
				st_nxt.csN   = '1;
				st_nxt.oeN   = 1'b1;
				st_nxt.pgmN  = 1'b1;
				st_nxt.state = EPB_IDLE;
			end
		endcase
	end

	// State register, inhibited and unpowered after reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r       <= '0;
			st_r.csN   <= '1;
			st_r.oeN   <= 1'b1;
			st_r.pgmN  <= 1'b1;
			st_r.state <= EPB_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign busy             = st_r.busy;
	assign done             = st_r.done;
	assign passed           = st_r.pass;
	assign failed           = st_r.fail;
	assign iterCount        = st_r.iter;
	assign readData         = st_r.rdata;
	assign epAddr           = st_r.addr;
	assign epDataOut        = st_r.data;
	assign epDataOe         = st_r.dOe;
	assign chipSelectN      = st_r.csN;
	assign outputGateN      = st_r.oeN;
	assign program_strobe_n = st_r.pgmN;
	assign vccOn            = st_r.vcc;
	assign vccProg          = st_r.vcc6;
	assign vppProg          = st_r.vpp;

endmodule

// >>> test/epb_programmer_sva.sv
// Checker on the programming controller pins
`timescale 1ns/1ps
module epb_programmer_sva #(
	parameter logic [epb_pkg::CNT_W-1:0] INIT_PULSE_CYC = 24'h000014,
	parameter logic [epb_pkg::CNT_W-1:0] STD_PULSE_CYC  = 24'h000032
) (
	// Clock and reset
	input logic                          mclk,
	input logic                          rst,
	// User side
	input logic                          startReq,
	input epb_pkg::epb_op_t              opSel,
	input logic                          busy,
	input logic                          done,
	input logic                          failed,
	input logic [3:0]                    iterCount,
	// Device pins and supplies
	input logic [epb_pkg::ADDR_W-1:0]    epAddr,
	input logic [epb_pkg::DATA_W-1:0]    epDataOut,
	input logic                          epDataOe,
	input logic [epb_pkg::NUM_DEV-1:0]   chipSelectN,
	input logic                          outputGateN,
	input logic                          program_strobe_n,
	input logic                          vccOn,
	input logic                          vccProg,
	input logic                          vppProg
);
	import epb_pkg::*;
	epb_op_t          curOp_r;
	logic [CNT_W-1:0] lowCnt_r;
	// Operation taken at start, and strobe low time for width checks
	always_ff @(posedge mclk) begin
		if (rst) begin
			curOp_r <= EPB_OP_STD;
			lowCnt_r <= '0;
		end else begin
			if (startReq && !busy) curOp_r <= opSel;
			lowCnt_r <= program_strobe_n ? '0 : lowCnt_r + 1'b1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_strobe_armed: assert property (!program_strobe_n |->
		vppProg && chipSelectN != 4'hf && epDataOe) else $error("strobe low unarmed");
	a_verify_read: assert property (!outputGateN |->
		program_strobe_n && !epDataOe && chipSelectN != 4'hf) else $error("bad verify");
	a_supply_order: assert property (vppProg |-> vccOn) else $error("vpp without vcc");
	a_pulse_supply: assert property (!program_strobe_n |->
		vccProg && vccOn) else $error("pulse below 6 V");
	a_pins_steady: assert property (!program_strobe_n |->
		$stable(epAddr) && $stable(epDataOut) && $stable(chipSelectN)) else $error("pins moved");
	a_std_width: assert property ($rose(program_strobe_n) && curOp_r == EPB_OP_STD |->
		lowCnt_r == STD_PULSE_CYC) else $error("standard pulse width");
	a_fast_width: assert property ($rose(program_strobe_n) && curOp_r == EPB_OP_FAST |->
		lowCnt_r == INIT_PULSE_CYC || lowCnt_r == CNT_W'(iterCount) * 24'h4 * INIT_PULSE_CYC)
		else $error("fast pulse width");
	a_fast_limit: assert property (done && failed && curOp_r == EPB_OP_FAST |->
		iterCount == 4'hf) else $error("gave up early");
	a_check_supply: assert property (busy && curOp_r == EPB_OP_CHECK |->
		!vppProg && !vccProg && program_strobe_n) else $error("check not at 5 V");
endmodule
bind epb_programmer epb_programmer_sva #(.INIT_PULSE_CYC(INIT_PULSE_CYC),
	.STD_PULSE_CYC(STD_PULSE_CYC)) i_sva (.mclk, .rst, .startReq, .opSel, .busy, .done,
	.failed, .iterCount, .epAddr, .epDataOut, .epDataOe, .chipSelectN, .outputGateN,
	.program_strobe_n, .vccOn, .vccProg, .vppProg);

// >>> test/epb_eprom_model.sv
// Behavioural EPROM at the controller's far side
`timescale 1ns/1ps
module epb_eprom_model (
	// Device pins
	input  logic [epb_pkg::ADDR_W-1:0] addr,
	input  logic [epb_pkg::DATA_W-1:0] dataIn,
	output logic [epb_pkg::DATA_W-1:0] dataOut,
	input  logic                       chipSelN,
	input  logic                       gateN,
	input  logic                       strobeN,
	// Vpp level and pulses a byte needs before it takes
	input  logic                       vppHigh,
	input  logic [4:0]                 need
);
	import epb_pkg::*;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] lastRead = 8'h00;
	logic              reading;
	int                pulses = 0;
	// Erased array reads all ones
	initial foreach (mem[i]) mem[i] = 8'hff;
	// Pulse counts only when selected at high Vpp; cells only clear
	always @(posedge strobeN) begin
		if (!chipSelN && vppHigh) begin
			pulses = pulses + 1;
			if (pulses >= need) mem[addr] = mem[addr] & dataIn;
		end
	end
	// Next byte starts its count once Vpp drops
	always @(negedge vppHigh) pulses = 0;
	// Released bus shows the inverse of the last byte, never a stale copy
	assign reading = !chipSelN && !gateN && strobeN;
	always @(*) if (reading) lastRead = mem[addr];
	assign dataOut = reading ? mem[addr] : ~lastRead;
endmodule

// >>> test/tb.sv
// Self-checking bench for the byte programming controller
`timescale 1ns/1ps
module tb;
	import epb_pkg::*;
	typedef struct {epb_op_t op; logic [13:0] a; logic [7:0] d, rd; logic [3:0] s, it;
		logic [4:0] n; logic p, ck;} epb_row_t;
	localparam logic [CNT_W-1:0] INIT = 24'h000014;
	localparam logic [CNT_W-1:0] STD  = 24'h000032;
	// Stimulus and observed pins
	logic               mclk = 1'h0;
	logic               rst = 1'h1;
	logic               startReq = 1'h0;
	epb_op_t            opSel = EPB_OP_STD;
	logic [ADDR_W-1:0]  addrIn = '0;
	logic [DATA_W-1:0]  dataIn = '0;
	logic [NUM_DEV-1:0] devSel = '0;
	logic [4:0]         need = 5'h01;
	logic               busy, done, passed, failed, dataOe, gateN, strobeN;
	logic               vccOn, vccProg, vppProg;
	logic [3:0]         iterCount, csN;
	logic [7:0]         readData, dataOut, devOut;
	logic [13:0]        epAddr;
	int                 errorCnt = 0;
	int                 compares = 0;
	// Ordinary cases, addresses in no particular order
	epb_row_t rows [9] = '{
		'{EPB_OP_STD, 14'h0005, 8'ha5, 8'ha5, 4'h1, 4'h0, 5'h01, 1'h1, 1'h1},
		'{EPB_OP_FAST, 14'h0006, 8'h3c, 8'h3c, 4'h1, 4'h3, 5'h03, 1'h1, 1'h1},
		'{EPB_OP_FAST, 14'h0007, 8'h00, 8'h00, 4'h1, 4'h1, 5'h01, 1'h1, 1'h1},
		'{EPB_OP_CHECK, 14'h0005, 8'ha5, 8'ha5, 4'h1, 4'h0, 5'h01, 1'h1, 1'h1},
		'{EPB_OP_CHECK, 14'h0009, 8'h12, 8'hff, 4'h1, 4'h0, 5'h01, 1'h0, 1'h1},
		'{EPB_OP_STD, 14'h0005, 8'hff, 8'ha5, 4'h1, 4'h0, 5'h01, 1'h0, 1'h1},
		'{EPB_OP_STD, 14'h000a, 8'h00, 8'h00, 4'h2, 4'h0, 5'h01, 1'h0, 1'h0},
		'{EPB_OP_CHECK, 14'h000a, 8'hff, 8'hff, 4'h1, 4'h0, 5'h01, 1'h1, 1'h1},
		'{EPB_OP_FAST, 14'h000b, 8'h55, 8'h55, 4'h1, 4'hf, 5'h0f, 1'h1, 1'h1}};
	epb_programmer #(.INIT_PULSE_CYC(INIT), .STD_PULSE_CYC(STD)) i_dut (.mclk, .rst, .startReq,
		.opSel, .addrIn, .dataIn, .devSel, .busy, .done, .passed, .failed, .iterCount, .readData,
		.epAddr, .epDataOut(dataOut), .epDataOe(dataOe), .epDataIn(devOut),
		.chipSelectN(csN), .outputGateN(gateN), .program_strobe_n(strobeN), .vccOn, .vccProg,
		.vppProg);
	epb_eprom_model i_dev (.addr(epAddr), .dataIn(dataOut), .dataOut(devOut),
		.chipSelN(csN[0]), .gateN, .strobeN, .vppHigh(vppProg), .need);
	// Free-running 200 MHz clock
	always #2.5 mclk = ~mclk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errorCnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic printVerdict();
		if (errorCnt == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic start(input epb_row_t r);
		@(posedge mclk);
		opSel <= r.op;
		addrIn <= r.a;
		dataIn <= r.d;
		devSel <= r.s;
		need <= r.n;
		startReq <= 1'h1;
		@(posedge mclk);
		startReq <= 1'h0;
	endtask
	// Run one operation and check its outcome after done settles
	task automatic run(input epb_row_t r);
		start(r);
		for (int k = 0; k < 30000 && done !== 1'h1; k++) begin
			@(posedge mclk);
			#1;
		end
		// A wait that ran out leaves done low and counts as a mismatch
		chk(16'(done), 16'h0001);
		if (r.ck) begin
			chk(16'({passed, failed}), 16'({r.p, !r.p}));
			chk(16'(readData), 16'(r.rd));
			if (r.op == EPB_OP_FAST) chk(16'(iterCount), 16'(r.it));
		end
	endtask
	// Main sequence, then the awkward cases
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		foreach (rows[i]) run(rows[i]);
		run('{EPB_OP_FAST, 14'h000c, 8'h0f, 8'hff, 4'h1, 4'hf, 5'h10, 1'h0, 1'h1});
		start('{EPB_OP_FAST, 14'h000d, 8'h00, 8'h00, 4'h1, 4'h0, 5'h10, 1'h0, 1'h0});
		repeat (1210) @(posedge mclk);
		rst <= 1'h1;
		@(posedge mclk);
		#1;
		chk(16'({csN, strobeN, gateN, vppProg, vccOn, busy}), 16'h01f8);
		@(posedge mclk);
		rst <= 1'h0;
		run('{EPB_OP_CHECK, 14'h000d, 8'hff, 8'hff, 4'h1, 4'h0, 5'h01, 1'h1, 1'h1});
		printVerdict();
	end
	// Cut a hang well past the planned run of some 66.5k cycles
	initial begin
		#450000;
		errorCnt++;
		printVerdict();
	end
endmodule
